// File: rtl/afp_parser.sv
module afp_parser (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Incoming command characters.
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	// Outgoing reply characters.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	// Flags seen by the logic rule engine.
	output logic [15:0] aux_flags,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	afp_pkg::afp_state_t state_ff;
	afp_pkg::afp_state_t nxt_state;
	afp_pkg::afp_reply_t reply_ff;
	afp_pkg::afp_counts_t counts_ff;

	logic is_write_ff;
	logic [7:0] addr_ff;
	logic [1:0] cnt_ff;
	logic [15:0] sel_ff;
	logic [15:0] val_ff;
	logic val_seen_ff;
	logic [15:0] flags_ff;
	logic [31:0] ctrl_ff;
	logic start_ff;
	logic ack_ff;
	logic tx_idle;

	logic accept;
	logic hex;
	logic [3:0] nib;
	logic frame_end;
	logic addr_hit;
	logic sel_all;
	logic sel_one;
	logic write_ok;
	logic do_reply;
	logic reply_ok;
	logic silent_end;
	logic bus_req;
	logic bus_wr;

	// New characters wait while a reply is queued or being sent, and while
	// the clock enable holds the parser frozen.
	assign rx_ready = clk_en && tx_idle && !start_ff;
	assign accept = clk_en && rx_valid && rx_ready;
	assign hex = afp_pkg::afp_is_hex(rx_data);
	assign nib = afp_pkg::afp_hex_val(rx_data);
	assign aux_flags = flags_ff;

	assign addr_hit = (addr_ff == afp_pkg::MODULE_ADDR);
	assign sel_all = (sel_ff == 16'h0000);
	assign sel_one = (sel_ff[15:12] == afp_pkg::SEL_ONE) &&
		(sel_ff[11:4] == 8'h00);

	// A frame ends on a carriage return in a state where the frame so far
	// was well formed.
	always_comb begin
		frame_end = 1'b0;
		if (accept && rx_data == afp_pkg::CH_CR && ctrl_ff[afp_pkg::CTRL_EN_BIT])
		begin
			case (state_ff)
				afp_pkg::ST_SEL,
				afp_pkg::ST_VAL,
				afp_pkg::ST_READ_END: frame_end = 1'b1;
				default: frame_end = 1'b0;
			endcase
		end
	end

	// A write needs four selector characters and at least one value
	// character; anything short of that, or a selector that is neither form,
	// is answered as an invalid operation.
	assign write_ok = (state_ff == afp_pkg::ST_VAL) && val_seen_ff &&
		(sel_all || sel_one);
	assign do_reply = frame_end && addr_hit;
	assign reply_ok = is_write_ff ? write_ok : 1'b1;
	assign silent_end = accept && ctrl_ff[afp_pkg::CTRL_EN_BIT] &&
		rx_data == afp_pkg::CH_CR && state_ff != afp_pkg::ST_IDLE &&
		!do_reply;

	always_comb begin
		nxt_state = state_ff;
		if (rx_data == afp_pkg::CH_WRITE || rx_data == afp_pkg::CH_READ) begin
			nxt_state = afp_pkg::ST_ADDR;
		end else if (rx_data == afp_pkg::CH_CR) begin
			nxt_state = afp_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				afp_pkg::ST_IDLE: nxt_state = afp_pkg::ST_IDLE;
				afp_pkg::ST_ADDR: begin
					if (!hex)
						nxt_state = afp_pkg::ST_DISCARD;
					else if (cnt_ff == 2'd1)
						nxt_state = afp_pkg::ST_CODE;
				end
				afp_pkg::ST_CODE: begin
					if (cnt_ff == 2'd0 && rx_data != afp_pkg::CH_CODE_HI)
						nxt_state = afp_pkg::ST_DISCARD;
					else if (cnt_ff == 2'd1 && rx_data != afp_pkg::CH_CODE_LO)
						nxt_state = afp_pkg::ST_DISCARD;
					else if (cnt_ff == 2'd1)
						nxt_state = is_write_ff ? afp_pkg::ST_SEL :
							afp_pkg::ST_READ_END;
				end
				afp_pkg::ST_SEL: begin
					if (!hex)
						nxt_state = afp_pkg::ST_DISCARD;
					else if (cnt_ff == 2'd3)
						nxt_state = afp_pkg::ST_VAL;
				end
				afp_pkg::ST_VAL: begin
					if (!hex)
						nxt_state = afp_pkg::ST_DISCARD;
				end
				afp_pkg::ST_READ_END: nxt_state = afp_pkg::ST_DISCARD;
				afp_pkg::ST_DISCARD: nxt_state = afp_pkg::ST_DISCARD;
				default: nxt_state = afp_pkg::ST_IDLE;
			endcase
		end
	end

	// Frame state. A delimiter restarts the frame from any state, so a frame
	// cut short by a lost character never swallows the next command.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= afp_pkg::ST_IDLE;
			is_write_ff <= 1'b0;
			cnt_ff <= 2'd0;
		end else if (clk_en) begin
			if (!ctrl_ff[afp_pkg::CTRL_EN_BIT]) begin
				state_ff <= afp_pkg::ST_IDLE;
				cnt_ff <= 2'd0;
			end else if (accept) begin
				state_ff <= nxt_state;
				if (rx_data == afp_pkg::CH_WRITE || rx_data == afp_pkg::CH_READ)
				begin
					is_write_ff <= (rx_data == afp_pkg::CH_WRITE);
					cnt_ff <= 2'd0;
				end else if (nxt_state != state_ff) begin
					cnt_ff <= 2'd0;
				end else begin
					cnt_ff <= cnt_ff + 2'd1;
				end
			end
		end
	end

	// Field capture. Value characters shift in from the right, so however
	// many arrive, the last one lands on flags 0 to 3 in an all-flags write.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			addr_ff <= 8'h00;
			sel_ff <= 16'h0000;
			val_ff <= 16'h0000;
			val_seen_ff <= 1'b0;
		end else if (clk_en && accept) begin
			if (rx_data == afp_pkg::CH_WRITE || rx_data == afp_pkg::CH_READ)
			begin
				val_ff <= 16'h0000;
				val_seen_ff <= 1'b0;
			end else if (hex) begin
				case (state_ff)
					afp_pkg::ST_ADDR: addr_ff <= {addr_ff[3:0], nib};
					afp_pkg::ST_SEL: sel_ff <= {sel_ff[11:0], nib};
					afp_pkg::ST_VAL: begin
						val_ff <= {val_ff[11:0], nib};
						val_seen_ff <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Flag store. A command write wins over a bus write in the same cycle.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags_ff <= afp_pkg::FLAGS_RESET;
		end else if (clk_en) begin
			if (do_reply && is_write_ff && write_ok) begin
				if (sel_all)
					flags_ff <= val_ff;
				else
					flags_ff[sel_ff[3:0]] <= val_ff[0];
			end else if (bus_wr && wb_adr_i == afp_pkg::ADR_FLAGS) begin
				if (wb_sel_i[0])
					flags_ff[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					flags_ff[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Reply launch, one pulse per answered frame.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			start_ff <= 1'b0;
			reply_ff <= '0;
		end else if (clk_en) begin
			start_ff <= do_reply;
			if (do_reply) begin
				reply_ff.ok <= reply_ok;
				reply_ff.has_flags <= !is_write_ff;
				reply_ff.flags <= flags_ff;
			end
		end
	end

	// Outcome counters, wrapping.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			counts_ff <= '0;
		end else if (clk_en) begin
			if (do_reply && reply_ok)
				counts_ff.ok <= counts_ff.ok + 8'h01;
			if (do_reply && !reply_ok)
				counts_ff.invalid <= counts_ff.invalid + 8'h01;
			if (silent_end)
				counts_ff.silent <= counts_ff.silent + 8'h01;
		end
	end

	afp_reply_tx u_reply_tx (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.start(start_ff),
		.reply(reply_ff),
		.idle(tx_idle),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.tx_data(tx_data)
	);

	// Wishbone: the answer comes one cycle after the request is seen, and
	// ack drops in the cycle after it was given.
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_wr = bus_req && wb_we_i;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_ff <= afp_pkg::CTRL_RESET;
		end else if (clk_en && bus_wr && wb_adr_i == afp_pkg::ADR_CTRL &&
			wb_sel_i[0]) begin
			ctrl_ff[afp_pkg::CTRL_EN_BIT] <= wb_dat_i[afp_pkg::CTRL_EN_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					afp_pkg::ADR_CTRL: wb_dat_o <= ctrl_ff;
					afp_pkg::ADR_FLAGS: wb_dat_o <= {16'h0000, flags_ff};
					afp_pkg::ADR_STATUS: begin
						wb_dat_o <= {1'b0, state_ff, 3'b000, !tx_idle, counts_ff};
					end
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// A frozen ack is hidden so that the master cannot take it twice.
	assign wb_ack_o = ack_ff && clk_en;

endmodule

// File: include/afp_pkg.sv
package afp_pkg;

	// Frame characters.
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_WRITE = 8'h23;
	localparam logic [7:0] CH_READ = 8'h24;
	localparam logic [7:0] CH_OK = 8'h3E;
	localparam logic [7:0] CH_INVALID = 8'h3F;
	localparam logic [7:0] CH_CODE_HI = 8'h56;
	localparam logic [7:0] CH_CODE_LO = 8'h64;

	localparam logic [7:0] MODULE_ADDR = 8'h01;
	localparam int FLAG_COUNT = 16;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;

	// Selector field values.
	localparam logic [3:0] SEL_ALL = 4'h0;
	localparam logic [3:0] SEL_ONE = 4'h1;

	// Reply lengths in characters.
	localparam logic [3:0] REPLY_SHORT_LEN = 4'h4;
	localparam logic [3:0] REPLY_LONG_LEN = 4'h8;

	// Register bus map, byte addresses.
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_FLAGS = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int STATUS_BUSY_BIT = 24;
	localparam int STATUS_STATE_LSB = 28;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CODE = 3'b010,
		ST_SEL = 3'b011,
		ST_VAL = 3'b100,
		ST_READ_END = 3'b101,
		ST_DISCARD = 3'b110
	} afp_state_t;

	typedef struct packed {
		logic ok;
		logic has_flags;
		logic [15:0] flags;
	} afp_reply_t;

	typedef struct packed {
		logic [7:0] silent;
		logic [7:0] invalid;
		logic [7:0] ok;
	} afp_counts_t;

	function automatic logic afp_is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
			(c >= 8'h61 && c <= 8'h66);
	endfunction

	function automatic logic [3:0] afp_hex_val(input logic [7:0] c);
		logic [7:0] v;
		v = 8'h00;
		if (c <= 8'h39)
			v = c - 8'h30;
		else if (c <= 8'h46)
			v = c - 8'h37;
		else
			v = c - 8'h57;
		return v[3:0];
	endfunction

	function automatic logic [7:0] afp_to_hex(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

endpackage

// File: rtl/afp_reply_tx.sv
module afp_reply_tx (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Reply request from the parser.
	input wire logic start,
	input wire afp_pkg::afp_reply_t reply,
	output logic idle,
	// Outgoing character stream.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data
);

	logic [63:0] shreg_ff;
	logic [3:0] left_ff;
	logic [7:0] lead;
	logic [7:0] a_hi;
	logic [7:0] a_lo;

	assign lead = reply.ok ? afp_pkg::CH_OK : afp_pkg::CH_INVALID;
	assign a_hi = afp_pkg::afp_to_hex(afp_pkg::MODULE_ADDR[7:4]);
	assign a_lo = afp_pkg::afp_to_hex(afp_pkg::MODULE_ADDR[3:0]);

	// A frozen block offers nothing, so the sink never takes a character
	// that the shift register will not advance past.
	assign tx_valid = clk_en && (left_ff != 4'h0);
	assign tx_data = shreg_ff[63:56];
	assign idle = (left_ff == 4'h0);

	// The flag field is sent most significant character first, so the last
	// character before the carriage return holds flags 0 to 3.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shreg_ff <= 64'h0000_0000_0000_0000;
			left_ff <= 4'h0;
		end else if (clk_en) begin
			if (start) begin
				if (reply.has_flags) begin
					shreg_ff <= {lead, a_hi, a_lo,
						afp_pkg::afp_to_hex(reply.flags[15:12]),
						afp_pkg::afp_to_hex(reply.flags[11:8]),
						afp_pkg::afp_to_hex(reply.flags[7:4]),
						afp_pkg::afp_to_hex(reply.flags[3:0]),
						afp_pkg::CH_CR};
					left_ff <= afp_pkg::REPLY_LONG_LEN;
				end else begin
					shreg_ff <= {lead, a_hi, a_lo, afp_pkg::CH_CR,
						32'h0000_0000};
					left_ff <= afp_pkg::REPLY_SHORT_LEN;
				end
			end else if (tx_valid && tx_ready) begin
				shreg_ff <= {shreg_ff[55:0], 8'h00};
				left_ff <= left_ff - 4'h1;
			end
		end
	end

endmodule

// File: tb/afp_parser_chk.sv
module afp_parser_chk (
	// Clock, reset and enable.
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Character links.
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic [15:0] aux_flags,
	// Wishbone.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire cr_take = rx_valid && rx_ready && rx_data == afp_pkg::CH_CR;
	wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	chk_ack_next: assert property (clk_en &&
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	chk_hold_flags: assert property (!clk_en |=> $stable(aux_flags))
		else $error("flags moved while frozen");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property (!wb_stb_i |=> !wb_ack_o)
		else $error("ack without request");
	chk_reply_kind: assert property (
		$rose(tx_valid) |-> tx_data == afp_pkg::CH_OK ||
		tx_data == afp_pkg::CH_INVALID) else $error("bad reply lead");
	chk_reply_cause: assert property (
		$rose(tx_valid) |-> $past(cr_take, 2)) else $error("reply not after CR");
	chk_rx_held: assert property (tx_valid |-> !rx_ready)
		else $error("rx open during reply");
	chk_tx_stand: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("reply char dropped");
	chk_cr_last: assert property (
		tx_valid && tx_ready && tx_data == afp_pkg::CH_CR |=> !tx_valid)
		else $error("chars after CR");
	chk_flags_quiet: assert property (
		$changed(aux_flags) |-> $past(cr_take) || $past(cr_take, 2) ||
		$past(wb_wr)) else $error("flags changed without cause");
	cover property ($rose(tx_valid) && tx_data == afp_pkg::CH_INVALID);
	cover property ($rose(tx_valid) && tx_data == afp_pkg::CH_OK);
	cover property (tx_valid && !tx_ready);
	cover property (wb_ack_o && wb_we_i);
endmodule

bind afp_parser afp_parser_chk afp_parser_chk_i (.core_clk, .sys_rst, .clk_en,
	.rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data,
	.aux_flags, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o);

// File: tb/afp_host.sv
module afp_host (
	// Clock.
	input wire logic core_clk,
	// Command characters.
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	// Reply characters.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data
);
	timeunit 1ns;
	timeprecision 1ns;
	bit slow = 0;
	string rsp = "";
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
	end
	// In slow mode the sink stalls every other cycle.
	always @(posedge core_clk) begin
		if (tx_valid && tx_ready)
			rsp = {rsp, string'(tx_data)};
		tx_ready <= slow ? !tx_ready : 1'b1;
	end
	// Frames go out whole, one character per accepted edge.
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_valid <= 1'b1;
			rx_data <= s[i];
			do begin
				@(posedge core_clk);
			end while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		// A released line must not keep showing the last character.
		rx_data <= ~s[s.len()-1];
	endtask
endmodule

// File: tb/tb_afp_parser.sv
module tb_afp_parser;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rx_valid, rx_ready, tx_valid, tx_ready, wb_ack_o;
	logic [7:0] rx_data, tx_data;
	logic [15:0] aux_flags;
	logic clk_en = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd;
	int err_total = 0;
	int checked = 0;
	int cyc_cnt = 0;
	int ok_n = 0;
	initial forever #50 core_clk = ~core_clk;
	afp_parser afp_parser_i (.core_clk, .sys_rst, .clk_en, .rx_valid,
		.rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data, .aux_flags,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	afp_host afp_host_i (.core_clk, .rx_valid, .rx_ready, .rx_data,
		.tx_valid, .tx_ready, .tx_data);
	task automatic wrap_up;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", w, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic frame(input string s, input string e, input logic [15:0] f);
		int n;
		string r;
		n = 0;
		afp_host_i.rsp = "";
		afp_host_i.send(s);
		r = afp_host_i.rsp;
		while (n < 60 && !(r.len() > 0 && r[r.len()-1] == 8'h0D)) begin
			@(posedge core_clk);
			r = afp_host_i.rsp;
			n++;
		end
		checked++;
		if (r != e) begin
			err_total++;
			$display("BAD reply to %s exp %s got %s", s, e, r);
		end
		cmp("flags", {16'h0000, f}, {16'h0000, aux_flags});
		if (e.len() > 0 && e[0] == 8'h3E)
			ok_n++;
	endtask
	task automatic t_regs;
		wb(1'b0, afp_pkg::ADR_CTRL, 32'h0000_0000);
		cmp("ctrl", afp_pkg::CTRL_RESET, rd);
		wb(1'b1, afp_pkg::ADR_FLAGS, 32'h0000_1234);
		frame("$01Vd\r", ">011234\r", 16'h1234);
		wb(1'b0, afp_pkg::ADR_FLAGS, 32'h0000_0000);
		cmp("flags reg", 32'h0000_1234, rd);
		wb(1'b0, 8'h0C, 32'hFFFF_FFFF);
		cmp("unmapped", 32'h0000_0000, rd);
		wb(1'b1, afp_pkg::ADR_CTRL, 32'h0000_0000);
		frame("#01Vd0000FFFF\r", "", 16'h1234);
		wb(1'b1, afp_pkg::ADR_CTRL, 32'h0000_0001);
	endtask
	task automatic t_writes;
		frame("#01Vd0000FFFF\r", ">01\r", 16'hFFFF);
		frame("#01Vd100E0\r", ">01\r", 16'hBFFF);
		frame("$01Vd\r", ">01BFFF\r", 16'hBFFF);
		frame("#01Vd00002b\r", ">01\r", 16'h002B);
		frame("$01Vd\r", ">01002B\r", 16'h002B);
		frame("#01Vd0000123456\r", ">01\r", 16'h3456);
		afp_host_i.slow = 1'b1;
		frame("#01Vd10001\r", ">01\r", 16'h3457);
		frame("$01Vd\r", ">013457\r", 16'h3457);
		afp_host_i.slow = 1'b0;
	endtask
	task automatic t_bad;
		frame("#01Vd2000F\r", "?01\r", 16'h3457);
		frame("#01Vd0000\r", "?01\r", 16'h3457);
		frame("#02Vd0000FFFF\r", "", 16'h3457);
		frame("#01Vx0000FFFF\r", "", 16'h3457);
		frame("$01Vd1\r", "", 16'h3457);
		frame("#01Vd#01Vd0000000F\r", ">01\r", 16'h000F);
		wb(1'b0, afp_pkg::ADR_STATUS, 32'h0000_0000);
		cmp("ok count", ok_n, {24'h00_0000, rd[7:0]});
		cmp("bad count", 32'h0000_0002, {24'h00_0000, rd[15:8]});
		cmp("silent count", 32'h0000_0003, {24'h00_0000, rd[23:16]});
		cmp("busy", 32'h0000_0000, {31'h0000_0000, rd[24]});
	endtask
	// A bus write issued while the block is frozen must wait for the enable.
	task automatic t_hold;
		logic [15:0] was;
		was = aux_flags;
		clk_en <= 1'b0;
		fork
			wb(1'b1, afp_pkg::ADR_FLAGS, 32'h0000_A5C3);
			begin
				repeat (5) @(posedge core_clk);
				cmp("frozen flags", {16'h0000, was}, {16'h0000, aux_flags});
				cmp("frozen ack", 32'h0000_0000, {31'h0000_0000, wb_ack_o});
				clk_en <= 1'b1;
			end
		join
		cmp("held write", 32'h0000_A5C3, {16'h0000, aux_flags});
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_writes();
		t_bad();
		t_hold();
		wrap_up();
	end
endmodule
